/* hdl/cso_pkg.sv */
// constants, codes and carrier types for the command source override block
package cso_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int CSO_PINS   = 5;
    localparam int CSO_FREQ_W = 16;
    localparam int CSO_CODE_W = 8;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_SRC_CFG   = 8'h00;
    localparam logic [7:0] OFS_OFFSET    = 8'h04;
    localparam logic [7:0] OFS_ASSIGN_LO = 8'h08;
    localparam logic [7:0] OFS_ASSIGN_HI = 8'h0c;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_SETPOINT  = 8'h14;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FLD_FREQ_SRC_LSB = 0;
    localparam int FLD_RUN_SRC_LSB  = 8;
    localparam int FLD_OFFSET_LSB   = 0;
    localparam int FLD_SIGN_BIT     = 16;
    localparam int FLD_ST_FREQ_LSB  = 0;
    localparam int FLD_ST_RUN_LSB   = 8;
    localparam int FLD_ST_KEYPAD    = 16;
    localparam int FLD_ST_TERMINAL  = 17;
    localparam int FLD_ST_OFFSET    = 18;
    localparam int FLD_ST_PENDING   = 19;
    localparam int FLD_ST_RUN       = 20;
    localparam int FLD_ST_PINS_LSB  = 24;

    // ****************************************
    // input function codes and source codes
    // ****************************************
    localparam logic [7:0] FUNC_KEYPAD_FORCE   = 8'h1f;
    localparam logic [7:0] FUNC_OFFSET_ENABLE  = 8'h32;
    localparam logic [7:0] FUNC_TERMINAL_FORCE = 8'h33;
    localparam logic [7:0] FSRC_POT      = 8'h00;
    localparam logic [7:0] FSRC_TERMINAL = 8'h01;
    localparam logic [7:0] FSRC_OPERATOR = 8'h02;
    localparam logic [7:0] FSRC_NETWORK  = 8'h03;
    localparam logic [7:0] FSRC_CALC     = 8'h0a;
    localparam logic [7:0] RSRC_TERMINAL = 8'h01;
    localparam logic [7:0] RSRC_OPERATOR = 8'h02;
    localparam logic [7:0] RSRC_NETWORK  = 8'h03;

    // ****************************************
    // reset values and setpoint limit
    // ****************************************
    localparam logic [7:0]  RST_FREQ_SRC = 8'h01;
    localparam logic [7:0]  RST_RUN_SRC  = 8'h01;
    localparam logic [15:0] RST_OFFSET   = 16'h0000;
    localparam logic        RST_SIGN     = 1'b0;
    localparam logic [7:0]  RST_ASSIGN   = 8'h00;
    localparam logic [15:0] FREQ_MAX     = 16'hffff;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [15:0] pot;
        logic [15:0] terminal;
        logic [15:0] operator;
        logic [15:0] network;
        logic [15:0] calc;
    } cso_freq_src_type;

    typedef struct packed {
        logic terminal;
        logic operator;
        logic network;
    } cso_run_src_type;

    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'b001,
        MODE_KEYPAD   = 3'b010,
        MODE_TERMINAL = 3'b100
    } cso_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_STOP = 2'b10
    } cso_state_type;

endpackage

/* hdl/cso_sync.sv */
// two-stage synchroniser for the terminal input pins
`timescale 1ns/1ns
module cso_sync
    import cso_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic [CSO_PINS-1:0] pin_in,
    output logic      [CSO_PINS-1:0] pin_sync
);

    logic [CSO_PINS-1:0] stage1_reg;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            stage1_reg <= '0;
            pin_sync   <= '0;
        end else begin
            stage1_reg <= pin_in;
            pin_sync   <= stage1_reg;
        end
    end

endmodule // cso_sync

/* hdl/cso_top.sv */
// command source override: source select, forcing, offset, register slave
`timescale 1ns/1ns
module cso_top
    import cso_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  resetn,
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic [CSO_PINS-1:0]   term_pin_in,
    input  cso_freq_src_type           freq_src_in,
    input  cso_run_src_type            run_src_in,
    input  wire logic                  motor_running,
    output logic                       run_cmd_out,
    output logic      [CSO_FREQ_W-1:0] freq_setpoint_out
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic has_func(
        input logic [CSO_PINS-1:0][7:0] asg,
        input logic [CSO_PINS-1:0]      pins,
        input logic [7:0]               code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < CSO_PINS; i++) begin
            if (pins[i] && asg[i] == code) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic [15:0] freq_select(
        input logic [7:0]       code,
        input cso_freq_src_type src
    );
        logic [15:0] f;
        case (code)
            FSRC_POT:      f = src.pot;
            FSRC_TERMINAL: f = src.terminal;
            FSRC_OPERATOR: f = src.operator;
            FSRC_NETWORK:  f = src.network;
            FSRC_CALC:     f = src.calc;
            default:       f = 16'h0000;
        endcase
        return f;
    endfunction

    function automatic logic run_select(
        input logic [7:0]      code,
        input cso_run_src_type src
    );
        logic r;
        case (code)
            RSRC_TERMINAL: r = src.terminal;
            RSRC_OPERATOR: r = src.operator;
            RSRC_NETWORK:  r = src.network;
            default:       r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] apply_offset(
        input logic [15:0] base,
        input logic [15:0] off,
        input logic        sub
    );
        logic [16:0] sum;
        logic [15:0] res;
        sum = {1'b0, base} + {1'b0, off};
        if (sub) begin
            res = (base >= off) ? 16'(base - off) : 16'h0000;
        end else begin
            res = sum[16] ? FREQ_MAX : sum[15:0];
        end
        return res;
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    logic [CSO_PINS-1:0]      pins_sync;
    logic [7:0]               freq_src_cfg_reg;
    logic [7:0]               run_src_cfg_reg;
    logic [15:0]              offset_val_reg;
    logic                     offset_sub_reg;
    logic [CSO_PINS-1:0][7:0] assign_reg;
    logic                     ack_reg;
    cso_mode_type             applied_mode_reg;
    cso_mode_type             req_mode;
    cso_state_type            state_reg;
    logic                     keypad_force;
    logic                     terminal_force;
    logic                     offset_en;
    logic [7:0]               eff_freq_src;
    logic [7:0]               eff_run_src;
    logic [15:0]              sel_freq;
    logic                     sel_run;
    logic                     mismatch;
    logic                     run_cmd_next;
    logic [15:0]              freq_next;
    logic [31:0]              status_word;
    logic [31:0]              read_word;

    default clocking ast_cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    cso_sync u_sync (
        .clock    (clock),
        .resetn   (resetn),
        .pin_in   (term_pin_in),
        .pin_sync (pins_sync)
    );

    // ****************************************
    // input function decode
    // ****************************************
    assign keypad_force   = has_func(assign_reg, pins_sync, FUNC_KEYPAD_FORCE);
    assign terminal_force = has_func(assign_reg, pins_sync,
                                     FUNC_TERMINAL_FORCE);
    assign offset_en      = has_func(assign_reg, pins_sync, FUNC_OFFSET_ENABLE);

    assign req_mode = keypad_force   ? MODE_KEYPAD :
                      terminal_force ? MODE_TERMINAL : MODE_NORMAL;

    // ****************************************
    // effective sources
    // ****************************************
    // forced or configured codes
    always_comb begin
        unique case (applied_mode_reg)
            MODE_KEYPAD: begin
                eff_freq_src = FSRC_OPERATOR;
                eff_run_src  = RSRC_OPERATOR;
            end
            MODE_TERMINAL: begin
                eff_freq_src = FSRC_TERMINAL;
                eff_run_src  = RSRC_TERMINAL;
            end
            MODE_NORMAL: begin
                eff_freq_src = freq_src_cfg_reg;
                eff_run_src  = run_src_cfg_reg;
            end
            default: begin
                eff_freq_src = freq_src_cfg_reg;
                eff_run_src  = run_src_cfg_reg;
            end
        endcase
    end

    assign sel_freq = freq_select(eff_freq_src, freq_src_in);
    assign sel_run  = run_select(eff_run_src, run_src_in);
    assign mismatch = (req_mode != applied_mode_reg);

    // ****************************************
    // source switch sequencing
    // ****************************************
    // hold old source until the motor stops
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_reg        <= ST_IDLE;
            applied_mode_reg <= MODE_NORMAL;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (mismatch && motor_running) begin
                        state_reg <= ST_STOP;
                    end else if (mismatch) begin
                        applied_mode_reg <= req_mode;
                    end
                end
                ST_STOP: begin
                    if (!motor_running) begin
                        applied_mode_reg <= req_mode;
                        state_reg        <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // run withheld while a switch is due
    assign run_cmd_next = (state_reg == ST_IDLE) && !mismatch && sel_run;

    assign freq_next = offset_en ?
                       apply_offset(sel_freq, offset_val_reg, offset_sub_reg) :
                       sel_freq;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            run_cmd_out       <= 1'b0;
            freq_setpoint_out <= 16'h0000;
        end else begin
            run_cmd_out       <= run_cmd_next;
            freq_setpoint_out <= freq_next;
        end
    end

    // ****************************************
    // register slave
    // ****************************************
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            freq_src_cfg_reg <= RST_FREQ_SRC;
            run_src_cfg_reg  <= RST_RUN_SRC;
            offset_val_reg   <= RST_OFFSET;
            offset_sub_reg   <= RST_SIGN;
            assign_reg       <= {CSO_PINS{RST_ASSIGN}};
        end else if (avs_write && ack_reg) begin
            case (avs_address)
                OFS_SRC_CFG: begin
                    freq_src_cfg_reg <= avs_writedata[FLD_FREQ_SRC_LSB +: 8];
                    run_src_cfg_reg  <= avs_writedata[FLD_RUN_SRC_LSB +: 8];
                end
                OFS_OFFSET: begin
                    offset_val_reg <= avs_writedata[FLD_OFFSET_LSB +: 16];
                    offset_sub_reg <= avs_writedata[FLD_SIGN_BIT];
                end
                OFS_ASSIGN_LO: begin
                    assign_reg[3:0] <= avs_writedata;
                end
                OFS_ASSIGN_HI: begin
                    assign_reg[4] <= avs_writedata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[FLD_ST_FREQ_LSB +: 8]        = eff_freq_src;
        status_word[FLD_ST_RUN_LSB +: 8]         = eff_run_src;
        status_word[FLD_ST_KEYPAD]               = keypad_force;
        status_word[FLD_ST_TERMINAL]             = terminal_force;
        status_word[FLD_ST_OFFSET]               = offset_en;
        status_word[FLD_ST_PENDING]              = mismatch;
        status_word[FLD_ST_RUN]                  = run_cmd_out;
        status_word[FLD_ST_PINS_LSB +: CSO_PINS] = pins_sync;
    end

    always_comb begin
        case (avs_address)
            OFS_SRC_CFG:   read_word = {16'h0000, run_src_cfg_reg,
                                        freq_src_cfg_reg};
            OFS_OFFSET:    read_word = {15'h0000, offset_sub_reg,
                                        offset_val_reg};
            OFS_ASSIGN_LO: read_word = assign_reg[3:0];
            OFS_ASSIGN_HI: read_word = {24'h000000, assign_reg[4]};
            OFS_STATUS:    read_word = status_word;
            OFS_SETPOINT:  read_word = {16'h0000, freq_setpoint_out};
            default:       read_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= read_word;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    // keypad source taken
    AST_KEYPAD_SRC: assert property (
        keypad_force && !motor_running |=>
        eff_freq_src == FSRC_OPERATOR && eff_run_src == RSRC_OPERATOR)
        else $error("keypad force did not select keypad sources");

    AST_NORMAL_SRC: assert property (
        !keypad_force && !terminal_force && !motor_running |=>
        eff_freq_src == freq_src_cfg_reg && eff_run_src == run_src_cfg_reg)
        else $error("configured sources not restored");

    AST_HOLD_RUNNING: assert property (
        mismatch && motor_running |=>
        applied_mode_reg == $past(applied_mode_reg) && !run_cmd_out)
        else $error("source switched while motor running");

    AST_KEYPAD_RUN_STOP: assert property (
        keypad_force && run_src_in.operator && motor_running &&
        applied_mode_reg != MODE_KEYPAD |=> !run_cmd_out)
        else $error("keypad run not stopped before handover");

    AST_OFFSET_OFF: assert property (
        !offset_en |=> freq_setpoint_out == $past(sel_freq))
        else $error("setpoint changed without offset enable");

    AST_OFFSET_SUB: assert property (
        offset_en && offset_sub_reg && sel_freq >= offset_val_reg |=>
        16'(freq_setpoint_out + $past(offset_val_reg)) == $past(sel_freq))
        else $error("offset not subtracted");

    AST_OFFSET_ADD: assert property (
        offset_en && !offset_sub_reg &&
        ({1'b0, sel_freq} + {1'b0, offset_val_reg}) <= {1'b0, FREQ_MAX} |=>
        16'(freq_setpoint_out - $past(offset_val_reg)) == $past(sel_freq))
        else $error("offset not added");

    AST_TERMINAL_SRC: assert property (
        terminal_force && !keypad_force && !motor_running |=>
        eff_freq_src == FSRC_TERMINAL && eff_run_src == RSRC_TERMINAL)
        else $error("terminal force did not select terminals");

    AST_TERMINAL_OFF: assert property (
        applied_mode_reg == MODE_TERMINAL && !terminal_force &&
        !keypad_force && !motor_running |=> applied_mode_reg == MODE_NORMAL)
        else $error("terminal force release not applied");

    AST_SWITCH_AFTER_STOP: assert property (
        state_reg == ST_STOP && !motor_running |=>
        applied_mode_reg == $past(req_mode) && state_reg == ST_IDLE)
        else $error("switch not completed after stop");

    AST_PRECEDENCE: assert property (
        keypad_force && terminal_force && !motor_running |=>
        applied_mode_reg == MODE_KEYPAD)
        else $error("keypad force did not take precedence");

endmodule // cso_top

/* tb/cso_far_side.sv */
// far-side model: terminal pins, keypad operator, sources and motor
`timescale 1ns/1ns
module cso_far_side
    import cso_pkg::*;
#(
    parameter int STOP_LAG = 20
)(
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                run_cmd_out,
    input  wire logic [CSO_PINS-1:0] pins_req,
    input  wire cso_freq_src_type    freq_req,
    input  wire cso_run_src_type     run_req,
    output logic      [CSO_PINS-1:0] term_pin_in,
    output cso_freq_src_type         freq_src_in,
    output cso_run_src_type          run_src_in,
    output logic                     motor_running
);
    logic [7:0] lag_reg;

    // pins, keypad and sources follow the bench
    assign term_pin_in = pins_req;
    assign freq_src_in = freq_req;
    assign run_src_in  = run_req;

    // motor coasts for a while after run drops
    always_ff @(posedge clock) begin
        if (!resetn) begin
            motor_running <= 1'b0;
            lag_reg       <= 8'h00;
        end else if (run_cmd_out) begin
            motor_running <= 1'b1;
            lag_reg       <= 8'h00;
        end else if (motor_running) begin
            lag_reg <= lag_reg + 8'h01;
            if (lag_reg == 8'(STOP_LAG - 1)) begin
                motor_running <= 1'b0;
            end
        end
    end
endmodule // cso_far_side

/* tb/testbench.sv */
// self-checking bench for the command source override block
`timescale 1ns/1ns
module testbench
    import cso_pkg::*;
();
    logic                  clock = 1'b0;
    logic                  resetn = 1'b0;
    logic [7:0]            avs_address = 8'h00;
    logic                  avs_read = 1'b0;
    logic                  avs_write = 1'b0;
    logic [31:0]           avs_writedata = 32'h0;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic [CSO_PINS-1:0]   term_pin_in;
    logic [CSO_PINS-1:0]   pins_req = '0;
    cso_freq_src_type      freq_src_in;
    cso_freq_src_type      freq_req = {16'h1000, 16'h2000, 16'h3000,
                                       16'h4000, 16'h5000};
    cso_run_src_type       run_src_in;
    cso_run_src_type       run_req = '0;
    logic                  motor_running;
    logic                  run_cmd_out;
    logic [CSO_FREQ_W-1:0] freq_setpoint_out;
    logic [31:0]           rd;
    int                    error_cnt = 0;
    int                    checks = 0;
    int                    cycles = 0;
    logic [7:0]            src_codes [5] = '{FSRC_POT, FSRC_TERMINAL,
                                   FSRC_OPERATOR, FSRC_NETWORK, FSRC_CALC};

    cso_top u_cso_top (.clock(clock), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .term_pin_in(term_pin_in), .freq_src_in(freq_src_in),
        .run_src_in(run_src_in), .motor_running(motor_running),
        .run_cmd_out(run_cmd_out), .freq_setpoint_out(freq_setpoint_out));

    cso_far_side u_cso_far_side (.clock(clock), .resetn(resetn),
        .run_cmd_out(run_cmd_out), .pins_req(pins_req),
        .freq_req(freq_req), .run_req(run_req), .term_pin_in(term_pin_in),
        .freq_src_in(freq_src_in), .run_src_in(run_src_in),
        .motor_running(motor_running));

    always #4 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_of_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            $display("[ERR] %0t bus stuck", $time);
        end
    endtask

    task automatic set_pins(input logic [CSO_PINS-1:0] p);
        @(posedge clock);
        pins_req <= p;
    endtask

    task automatic expect_out(input logic [15:0] sp, input logic run);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((freq_setpoint_out !== sp || run_cmd_out !== run)
                   && n < 40);
        chk({16'h0, freq_setpoint_out}, {16'h0, sp});
        chk({31'h0, run_cmd_out}, {31'h0, run});
    endtask

    // stop first, hold run low while motor turns, then hand over
    task automatic switch_check(input logic [15:0] sp, input logic run);
        int   n;
        logic bad;
        n = 0;
        bad = 1'b0;
        while (run_cmd_out !== 1'b0 && n < 10) begin
            @(negedge clock);
            n++;
        end
        chk({31'h0, run_cmd_out}, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, rd[FLD_ST_PENDING]}, 32'h1);
        n = 0;
        while (motor_running === 1'b1 && n < 60) begin
            @(negedge clock);
            if (run_cmd_out !== 1'b0) begin
                bad = 1'b1;
            end
            n++;
        end
        chk({31'h0, bad}, 32'h0);
        expect_out(sp, run);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        bus(1'b0, OFS_SRC_CFG, 32'h0);
        chk(rd, {16'h0, RST_RUN_SRC, RST_FREQ_SRC});
        bus(1'b0, OFS_OFFSET, 32'h0);
        chk(rd, {15'h0, RST_SIGN, RST_OFFSET});
        bus(1'b1, 8'h18, 32'hffffffff);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        expect_out(16'h2000, 1'b0);
        bus(1'b0, OFS_SETPOINT, 32'h0);
        chk(rd, 32'h0000_2000);
    endtask

    task automatic t_offset();
        logic [15:0] v;
        bus(1'b1, OFS_ASSIGN_LO, {8'h00, FUNC_OFFSET_ENABLE, 16'h0000});
        bus(1'b1, OFS_ASSIGN_HI, 32'h0);
        for (int i = 0; i < 5; i++) begin
            v = 16'((i + 1) * 4096);
            set_pins(5'b00000);
            bus(1'b1, OFS_SRC_CFG, {16'h0, RSRC_NETWORK, src_codes[i]});
            bus(1'b1, OFS_OFFSET, {15'h0, 1'b0, 16'h0123});
            expect_out(v, 1'b0);
            set_pins(5'b00100);
            expect_out(v + 16'h0123, 1'b0);
            bus(1'b1, OFS_OFFSET, {15'h0, 1'b1, 16'h0123});
            expect_out(v - 16'h0123, 1'b0);
        end
        set_pins(5'b00000);
        bus(1'b1, OFS_OFFSET, 32'h0);
    endtask

    task automatic t_force();
        logic [15:0] sp [4] = '{16'h4000, 16'h3000, 16'h2000, 16'h3000};
        logic [15:0] ef [4] = '{16'h0303, 16'h0202, 16'h0101, 16'h0202};
        // sources kept off terminal and operator
        bus(1'b1, OFS_SRC_CFG, {16'h0, RSRC_NETWORK, FSRC_NETWORK});
        bus(1'b1, OFS_ASSIGN_LO, {8'h00, FUNC_OFFSET_ENABLE,
            FUNC_TERMINAL_FORCE, FUNC_KEYPAD_FORCE});
        for (int i = 0; i < 4; i++) begin
            set_pins(5'(i));
            expect_out(sp[i], 1'b0);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk({16'h0, rd[15:0]}, {16'h0, ef[i]});
        end
        set_pins(5'b00000);
        expect_out(16'h4000, 1'b0);
    endtask

    task automatic t_switch();
        @(posedge clock);
        run_req <= '{terminal: 1'b0, operator: 1'b1, network: 1'b1};
        expect_out(16'h4000, 1'b1);
        set_pins(5'b00001);
        switch_check(16'h3000, 1'b1);
        set_pins(5'b00010);
        switch_check(16'h2000, 1'b0);
        set_pins(5'b00000);
        expect_out(16'h4000, 1'b1);
    endtask

    // reset again while the motor runs
    task automatic t_mid_reset();
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        chk({31'h0, run_cmd_out}, 32'h0);
        chk({16'h0, freq_setpoint_out}, 32'h0);
        bus(1'b0, OFS_SRC_CFG, 32'h0);
        chk(rd, {16'h0, RST_RUN_SRC, RST_FREQ_SRC});
        expect_out(16'h2000, 1'b0);
    endtask

    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_offset();
        t_force();
        t_switch();
        t_mid_reset();
        end_of_test();
    end
endmodule // testbench
